// >>> common/ocpwm_defines.svh
// Register offsets, field positions, reset values and codes for the compare channel.
`ifndef OCPWM_DEFINES_SVH
`define OCPWM_DEFINES_SVH
`define OCPWM_OFS_CTRL 5'h00
`define OCPWM_OFS_PRI 5'h04
`define OCPWM_OFS_SEC 5'h08
`define OCPWM_OFS_PER0 5'h0c
`define OCPWM_OFS_PER1 5'h10
`define OCPWM_OFS_STAT 5'h14
`define OCPWM_BIT_TSEL 3
`define OCPWM_BIT_FLT 4
`define OCPWM_BIT_IDLE 13
`define OCPWM_CTRL_WMASK 16'h200f
`define OCPWM_RST16 16'h0000
`define OCPWM_M_OFF 3'h0
`define OCPWM_M_HIGH 3'h1
`define OCPWM_M_LOW 3'h2
`define OCPWM_M_TOG 3'h3
`define OCPWM_M_ONE 3'h4
`define OCPWM_M_CONT 3'h5
`define OCPWM_M_PWM 3'h6
`define OCPWM_M_PWMF 3'h7
`define OCPWM_RESP_OK 2'h0
`define OCPWM_RESP_ERR 2'h2
`endif

// >>> common/ocpwm_pkg.sv
// Types shared by the compare channel.
package ocpwm_pkg;
    typedef enum logic [3:0] {
        OCPWM_IDLE = 4'h1,
        OCPWM_WAIT_RISE = 4'h2,
        OCPWM_WAIT_FALL = 4'h4,
        OCPWM_DONE = 4'h8
    } ocpwm_pulse_e;

    typedef struct packed {
        logic [15:0] ctrl;
        logic [15:0] pri;
        logic [15:0] sec;
        logic [15:0] per0;
        logic [15:0] per1;
        logic [15:0] tmr0;
        logic [15:0] tmr1;
        logic pin;
        logic irq;
        logic dma;
        ocpwm_pulse_e pst;
        logic aw_done;
        logic w_done;
        logic [4:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ocpwm_state_s;
endpackage

// >>> logic/ocpwm_channel.sv
// Output compare channel with glitchless PWM, two local time bases and an AXI4-Lite register slave.
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`include "ocpwm_defines.svh"

// Operation
// RULE_01: PWM period lasts period register value plus one counts.
// RULE_02: Secondary duty copies into primary only on period match.
// RULE_03: Primary compare register is read-only while a PWM mode is active.
// RULE_04: First PWM period uses the value already in the primary register.
// RULE_05: Primary zero in PWM keeps the pin low all period.
// RULE_06: Primary above period in PWM holds the pin high.
// RULE_07: Primary equal to period gives exactly one low count.
// RULE_08: Software sets period, duty, initial duty, interrupts, mode, then starts timer.
// RULE_09: Software initialises the primary register before first enable.
// RULE_10: Fault use requires software to enable the channel interrupt.
// RULE_11: Mode zero disables the channel.
// RULE_12: Mode 001 starts low, compare event drives high.
// RULE_13: Mode 010 starts high, compare event drives low.
// RULE_14: Mode 011 toggles the pin on each compare event.
// RULE_15: Mode 100 starts low and makes one pulse.
// RULE_16: Read-only fault status at bit 4, cleared by hardware.
// RULE_17: Writable time base select at bit 3 picks the compared timer.
// RULE_18: Only channels one and two raise a DMA request.
// RULE_19: Mode 101 starts low and pulses every compare cycle.
// RULE_20: Pulse modes rise on primary match, fall on secondary match.
// RULE_21: Single pulse holds low after trailing edge and sets the flag.
// RULE_22: Timer returns to zero on period match and keeps counting.
// RULE_23: Modes 110/111 are PWM; fault forces pin low and sets status. Here only mode 111 applies the fault; mode 110 ignores FAULT_N.
// RULE_24: Idle-stop bit at 13 halts the channel in processor idle.
module ocpwm_channel
    import ocpwm_pkg::*;
#(
    parameter int CHANNEL = 1 // Channel number; only 1 and 2 may request DMA.
) (
    input wire logic CORE_CLK, // 40 MHz instruction clock.
    input wire logic RST_N, // Asynchronous reset, active low.
    input wire logic TIMER_RUN0, // Run enable of time base 0.
    input wire logic TIMER_RUN1, // Run enable of time base 1.
    input wire logic CPU_IDLE, // Processor is in idle mode.
    input wire logic FAULT_N, // Fault input, active low.
    output logic COMPARE_OUT, // Compare output pin.
    output logic CHANNEL_IRQ, // Channel event pulse.
    output logic DMA_REQ, // DMA request pulse.
    input wire logic S_AXI_AWVALID, // Write address valid.
    output logic S_AXI_AWREADY, // Write address ready.
    input wire logic [4:0] S_AXI_AWADDR, // Write address.
    input wire logic S_AXI_WVALID, // Write data valid.
    output logic S_AXI_WREADY, // Write data ready.
    input wire logic [31:0] S_AXI_WDATA, // Write data.
    input wire logic [3:0] S_AXI_WSTRB, // Write strobes.
    output logic S_AXI_BVALID, // Write response valid.
    input wire logic S_AXI_BREADY, // Write response ready.
    output logic [1:0] S_AXI_BRESP, // Write response.
    input wire logic S_AXI_ARVALID, // Read address valid.
    output logic S_AXI_ARREADY, // Read address ready.
    input wire logic [4:0] S_AXI_ARADDR, // Read address.
    output logic S_AXI_RVALID, // Read data valid.
    input wire logic S_AXI_RREADY, // Read data ready.
    output logic [31:0] S_AXI_RDATA, // Read data.
    output logic [1:0] S_AXI_RRESP // Read response.
);

    ocpwm_state_s st;
    ocpwm_state_s next_st;

    logic [2:0] mode;
    logic is_pwm;
    logic halted;
    logic [15:0] tmr;
    logic [15:0] per;
    logic run;
    logic per_hit;
    logic pri_hit;
    logic sec_hit;
    logic wr_go;
    logic [15:0] wr16;

    // ****************************************************************
    // Time base and compare events
    // ****************************************************************
    assign mode = st.ctrl[2:0];
    assign is_pwm = mode[2] & mode[1];
    assign halted = st.ctrl[`OCPWM_BIT_IDLE] & CPU_IDLE; // RULE_24
    assign tmr = st.ctrl[`OCPWM_BIT_TSEL] ? st.tmr1 : st.tmr0; // RULE_17
    assign per = st.ctrl[`OCPWM_BIT_TSEL] ? st.per1 : st.per0; // RULE_17
    assign run = st.ctrl[`OCPWM_BIT_TSEL] ? TIMER_RUN1 : TIMER_RUN0;
    // Events count only on counting edges so a stopped timer gives no repeats.
    assign per_hit = run & (tmr == per);
    assign pri_hit = run & (tmr == st.pri);
    assign sec_hit = run & (tmr == st.sec);

    // ****************************************************************
    // Bus handshake
    // ****************************************************************
    assign S_AXI_AWREADY = ~st.aw_done & ~st.bvalid;
    assign S_AXI_WREADY = ~st.w_done & ~st.bvalid;
    assign S_AXI_ARREADY = ~st.rvalid;
    assign S_AXI_BVALID = st.bvalid;
    assign S_AXI_BRESP = st.bresp;
    assign S_AXI_RVALID = st.rvalid;
    assign S_AXI_RDATA = st.rdata;
    assign S_AXI_RRESP = st.rresp;
    assign COMPARE_OUT = st.pin;
    assign CHANNEL_IRQ = st.irq;
    assign DMA_REQ = st.dma;

    always_comb begin
        logic [4:0] wa;
        logic [31:0] wd;
        logic [3:0] ws;
        logic [15:0] rd;
        logic ok;
        logic fire;
        wa = st.awaddr;
        wd = st.wdata;
        ws = st.wstrb;
        rd = `OCPWM_RST16;
        ok = 1'b1;
        fire = 1'b0;
        next_st = st;
        next_st.irq = 1'b0;
        next_st.dma = 1'b0;
        wr16 = `OCPWM_RST16;
        wr_go = 1'b0;

        // Timers: wrap to zero on period match, keep counting.
        if (TIMER_RUN0) begin
            next_st.tmr0 = (st.tmr0 == st.per0) ? `OCPWM_RST16 : st.tmr0 + 16'h0001; // RULE_22 RULE_01
        end
        if (TIMER_RUN1) begin
            next_st.tmr1 = (st.tmr1 == st.per1) ? `OCPWM_RST16 : st.tmr1 + 16'h0001; // RULE_22 RULE_01
        end

        // Compare output behaviour.
        if (!halted) begin
            case (mode)
                `OCPWM_M_OFF: begin
                    next_st.pin = 1'b0; // RULE_11
                    next_st.pst = OCPWM_IDLE;
                end
                `OCPWM_M_HIGH: if (pri_hit) begin
                    next_st.pin = 1'b1; // RULE_12
                    fire = 1'b1;
                end
                `OCPWM_M_LOW: if (pri_hit) begin
                    next_st.pin = 1'b0; // RULE_13
                    fire = 1'b1;
                end
                `OCPWM_M_TOG: if (pri_hit) begin
                    next_st.pin = ~st.pin; // RULE_14
                    fire = 1'b1;
                end
                `OCPWM_M_ONE, `OCPWM_M_CONT: begin
                    case (st.pst)
                        OCPWM_WAIT_RISE: if (pri_hit) begin
                            next_st.pin = 1'b1; // RULE_20
                            next_st.pst = OCPWM_WAIT_FALL;
                        end
                        OCPWM_WAIT_FALL: if (sec_hit) begin
                            next_st.pin = 1'b0; // RULE_20
                            fire = 1'b1; // RULE_21
                            next_st.pst = mode[0] ? OCPWM_WAIT_RISE : OCPWM_DONE; // RULE_19 RULE_21
                        end
                        OCPWM_DONE: next_st.pin = 1'b0; // RULE_21
                        default: next_st.pst = OCPWM_WAIT_RISE; // RULE_15
                    endcase
                end
                default: begin
                    // PWM: the level for the coming count is decided one edge ahead, so the pin
                    // stays a flip-flop output and is high exactly for counts below the duty value.
                    if (per_hit) begin
                        next_st.pri = st.sec; // RULE_02
                        next_st.pin = (st.sec != `OCPWM_RST16); // RULE_05
                        fire = 1'b1;
                    end else if (run) begin
                        next_st.pin = ((tmr + 16'h0001) < st.pri); // RULE_04 RULE_06 RULE_07
                    end
                    if (mode == `OCPWM_M_PWMF && !FAULT_N) begin
                        next_st.pin = 1'b0; // RULE_23
                        next_st.ctrl[`OCPWM_BIT_FLT] = 1'b1; // RULE_23
                    end
                end
            endcase
        end
        next_st.irq = fire;
        next_st.dma = fire & ((CHANNEL == 1) || (CHANNEL == 2)); // RULE_18

        // Write channel: address and data accepted in either order.
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            next_st.aw_done = 1'b1;
            next_st.awaddr = S_AXI_AWADDR;
            wa = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            next_st.w_done = 1'b1;
            next_st.wdata = S_AXI_WDATA;
            next_st.wstrb = S_AXI_WSTRB;
            wd = S_AXI_WDATA;
            ws = S_AXI_WSTRB;
        end
        if (next_st.aw_done && next_st.w_done && !st.bvalid) begin
            wr_go = 1'b1;
            wr16[7:0] = ws[0] ? wd[7:0] : 8'h00;
            wr16[15:8] = ws[1] ? wd[15:8] : 8'h00;
            next_st.aw_done = 1'b0;
            next_st.w_done = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = `OCPWM_RESP_OK;
            case (wa)
                `OCPWM_OFS_CTRL: begin
                    next_st.ctrl = (next_st.ctrl & ~`OCPWM_CTRL_WMASK) | (wr16 & `OCPWM_CTRL_WMASK); // RULE_17 RULE_24
                    // Leaving fault PWM clears the fault; rewriting a pulse mode re-arms it.
                    // A fault latched in this very cycle wins over the clear, so none is lost.
                    if (wr16[2:0] != `OCPWM_M_PWMF && !(mode == `OCPWM_M_PWMF && !FAULT_N && !halted)) begin
                        next_st.ctrl[`OCPWM_BIT_FLT] = 1'b0; // RULE_16
                    end
                    next_st.pst = OCPWM_WAIT_RISE;
                    if (wr16[2:0] == `OCPWM_M_LOW) begin
                        next_st.pin = 1'b1; // RULE_13
                    end else if (wr16[2:0] != `OCPWM_M_TOG && !(wr16[2] & wr16[1])) begin
                        next_st.pin = 1'b0; // RULE_12 RULE_15 RULE_19
                    end
                end
                `OCPWM_OFS_PRI: if (!is_pwm) next_st.pri = wr16; // RULE_03
                `OCPWM_OFS_SEC: next_st.sec = wr16; // RULE_02
                `OCPWM_OFS_PER0: next_st.per0 = wr16;
                `OCPWM_OFS_PER1: next_st.per1 = wr16;
                `OCPWM_OFS_STAT: ;
                default: next_st.bresp = `OCPWM_RESP_ERR;
            endcase
        end
        if (st.bvalid && S_AXI_BREADY) begin
            next_st.bvalid = 1'b0;
        end

        // Read channel.
        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            case (S_AXI_ARADDR)
                `OCPWM_OFS_CTRL: rd = st.ctrl; // RULE_16
                `OCPWM_OFS_PRI: rd = st.pri;
                `OCPWM_OFS_SEC: rd = st.sec;
                `OCPWM_OFS_PER0: rd = st.per0;
                `OCPWM_OFS_PER1: rd = st.per1;
                `OCPWM_OFS_STAT: rd = tmr;
                default: ok = 1'b0;
            endcase
            next_st.rvalid = 1'b1;
            next_st.rdata = {16'h0000, rd};
            next_st.rresp = ok ? `OCPWM_RESP_OK : `OCPWM_RESP_ERR;
        end else if (st.rvalid && S_AXI_RREADY) begin
            next_st.rvalid = 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_off_low: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RULE_11
        (mode == `OCPWM_M_OFF && !wr_go) |=> !COMPARE_OUT) else $error("disabled channel drove pin");
    a_dbuf_load: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RULE_02
        (is_pwm && per_hit && !halted) |=> (st.pri == $past(st.sec))) else $error("duty not loaded at period");
    a_pri_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RULE_03
        (is_pwm && !per_hit && !wr_go) |=> $stable(st.pri)) else $error("primary changed in PWM");
    a_zero_low: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RULE_05
        (is_pwm && run && !halted && st.pri == 16'h0000 && !per_hit && !wr_go) |=> !COMPARE_OUT)
        else $error("zero duty not low");
    // The duty compare is checked on the pin itself, one count after its decision.
    a_full_high: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RULE_06
        (mode == `OCPWM_M_PWM && run && !halted && !per_hit && !wr_go && tmr < per && st.pri > per) |=> COMPARE_OUT)
        else $error("duty above period not high");
    a_low_at_duty: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RULE_07
        (mode == `OCPWM_M_PWM && tmr == st.pri && st.pri != 16'h0000 && $past(run) && $past(is_pwm)
        && !$past(halted) && !$past(wr_go)) |-> !COMPARE_OUT) else $error("pin high at duty count");
    a_wrap_zero: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RULE_22
        (TIMER_RUN0 && st.tmr0 == st.per0) |=> (st.tmr0 == 16'h0000)) else $error("timer did not wrap");
    a_fault_set: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RULE_23
        (mode == `OCPWM_M_PWMF && !FAULT_N && !halted && !wr_go) |=> (!COMPARE_OUT && st.ctrl[4]))
        else $error("fault not applied");
    a_idle_freeze: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RULE_24
        (halted && !wr_go) |=> $stable(COMPARE_OUT)) else $error("pin moved while idle");
    a_one_done: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RULE_21
        (mode == `OCPWM_M_ONE && st.pst == OCPWM_DONE && !wr_go) |=> !COMPARE_OUT) else $error("extra pulse");
    a_tog_flip: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RULE_14
        (mode == `OCPWM_M_TOG && pri_hit && !halted && !wr_go) |=> (COMPARE_OUT != $past(COMPARE_OUT)))
        else $error("toggle missed");
    a_dma_chan: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RULE_18
        DMA_REQ == (CHANNEL_IRQ && (CHANNEL == 1 || CHANNEL == 2))) else $error("dma on wrong channel");
    a_bresp_two: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (S_AXI_BVALID && !S_AXI_BREADY) |=> S_AXI_BVALID) else $error("bvalid dropped");

    c_pwm_load: cover property (@(posedge CORE_CLK) disable iff (!RST_N) is_pwm && per_hit);
    c_one_pulse: cover property (@(posedge CORE_CLK) disable iff (!RST_N) st.pst == OCPWM_DONE);
    c_fault: cover property (@(posedge CORE_CLK) disable iff (!RST_N) st.ctrl[4]);
    c_write: cover property (@(posedge CORE_CLK) disable iff (!RST_N) wr_go);
    c_idle_hold: cover property (@(posedge CORE_CLK) disable iff (!RST_N) halted && is_pwm);

endmodule // ocpwm_channel

// >>> bench/ocpwm_load.sv
// Load model hung on the compare pin; it tallies high samples and rising edges.
module ocpwm_load (
    input wire logic clk, // Bench clock.
    input wire logic rst_n, // Reset, active low.
    input wire logic pin, // Compare pin level.
    input wire logic clr, // Restart the tallies.
    output int highs, // Samples seen high.
    output int rises // Rising edges seen.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last;

    // Restarting keeps the last level, so a window opened while the pin is high
    // does not invent a rising edge.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            highs <= 0;
            rises <= 0;
            last <= 1'b0;
        end else if (clr) begin
            highs <= 0;
            rises <= 0;
            last <= pin;
        end else begin
            highs <= highs + int'(pin);
            rises <= rises + int'(pin && !last);
            last <= pin;
        end
    end
endmodule // ocpwm_load

// >>> bench/testbench.sv
// Self-checking bench for the compare channel with random PWM duties.
`include "ocpwm_defines.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] A_CTL = 5'(`OCPWM_OFS_CTRL);
    localparam logic [4:0] A_PRI = 5'(`OCPWM_OFS_PRI);
    localparam logic [4:0] A_SEC = 5'(`OCPWM_OFS_SEC);
    localparam logic [4:0] A_PER0 = 5'(`OCPWM_OFS_PER0);
    localparam logic [4:0] A_PER1 = 5'(`OCPWM_OFS_PER1);
    localparam logic [4:0] A_TMR = 5'(`OCPWM_OFS_STAT);
    localparam logic [1:0] OK = `OCPWM_RESP_OK;
    localparam logic [1:0] ERR = `OCPWM_RESP_ERR;
    logic clk = 0, rst_n = 0, run0 = 0, run1 = 0, idle = 0, flt_n = 1, clr = 0;
    logic awv = 0, wv = 0, arv = 0, bready = 0, rready = 0;
    logic [4:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rdata, rdv;
    logic [1:0] rs, bresp, rresp;
    logic pin, irq, dma, awrdy, wrdy, bv, arrdy, rv;
    int failures = 0, checked = 0, seed = 32'h14ae, hi, ri, nirq, ndma, d;
    int dl[6] = '{0, 3, 7, 9, 0, 0};

    ocpwm_channel #(.CHANNEL(1)) dut (.CORE_CLK(clk), .RST_N(rst_n), .TIMER_RUN0(run0), .TIMER_RUN1(run1),
        .CPU_IDLE(idle), .FAULT_N(flt_n), .COMPARE_OUT(pin), .CHANNEL_IRQ(irq), .DMA_REQ(dma),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy), .S_AXI_AWADDR(awa), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wrdy), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_BVALID(bv),
        .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arrdy),
        .S_AXI_ARADDR(ara), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp));
    ocpwm_load load (.clk(clk), .rst_n(rst_n), .pin(pin), .clr(clr), .highs(hi), .rises(ri));

    initial begin
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (clr) begin
            nirq <= 0;
            ndma <= 0;
        end else begin
            nirq <= nirq + int'(irq);
            ndma <= ndma + int'(dma);
        end
    end

    // ****************************************************************
    // Bus tasks and comparison
    // ****************************************************************
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Ready is looked at on the falling edge, so the decision taken at the next
    // rising edge never races the slave's own update.
    task automatic wr(input logic [4:0] a, input logic [15:0] v, input logic [1:0] er);
        logic ta, tw, tb;
        int n;
        @(posedge clk);
        awv <= 1;
        wv <= 1;
        awa <= a;
        wd <= {16'h0000, v};
        bready <= 1;
        tb = 0;
        for (n = 0; n < 40 && !tb; n++) begin
            @(negedge clk);
            ta = awv && awrdy;
            tw = wv && wrdy;
            tb = bv;
            rs = bresp;
            @(posedge clk);
            if (ta) awv <= 0;
            if (tw) wv <= 0;
        end
        bready <= 0;
        chk("bresp", 32'(rs), 32'(er));
        if (!tb) begin
            failures++;
            conclude();
        end
    endtask

    task automatic rd(input logic [4:0] a, input logic [1:0] er, output logic [31:0] v);
        logic ta, tr;
        int n;
        @(posedge clk);
        arv <= 1;
        ara <= a;
        rready <= 1;
        tr = 0;
        for (n = 0; n < 40 && !tr; n++) begin
            @(negedge clk);
            ta = arv && arrdy;
            tr = rv;
            v = rdata;
            rs = rresp;
            @(posedge clk);
            if (ta) arv <= 0;
        end
        rready <= 0;
        chk("rresp", 32'(rs), 32'(er));
        if (!tr) begin
            failures++;
            conclude();
        end
    endtask

    task automatic rdc(input logic [4:0] a, input logic [31:0] e);
        rd(a, OK, rdv);
        chk("rdata", rdv, e);
    endtask

    task automatic meas;
        clr <= 1;
        @(posedge clk);
        clr <= 0;
        repeat (32) @(posedge clk);
        #1;
    endtask

    function automatic int exp_hi(input int dc);
        if (dc == 0) return 0;
        if (dc > 7) return 32;
        return 4 * dc;
    endfunction

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1;
        for (d = 0; d < 6; d++) rdc(5'(4 * d), 32'h0);
        rd(5'h18, ERR, rdv);
        wr(5'h18, 16'hffff, ERR);
        dl[4] = $unsigned($random(seed)) % 10;
        dl[5] = $unsigned($random(seed)) % 10;
        foreach (dl[i]) begin
            wr(A_CTL, 16'h0000, OK);
            wr(A_PER0, 16'h0007, OK);
            wr(A_SEC, 16'(dl[i]), OK);
            wr(A_PRI, 16'(dl[i]), OK);
            wr(A_CTL, 16'h0006, OK);
            run0 <= 1;
            repeat (20) @(posedge clk);
            meas();
            chk("highs", hi, exp_hi(dl[i]));
            chk("rises", ri, (dl[i] > 0 && dl[i] < 8) ? 4 : 0);
            chk("irqs", nirq, 4);
            chk("dmas", ndma, 4);
            rdc(A_PRI, dl[i]);
        end
        run0 <= 0;
        wr(A_PRI, 16'h0055, OK);
        wr(A_SEC, 16'h0005, OK);
        rdc(A_PRI, dl[5]);
        run0 <= 1;
        repeat (10) @(posedge clk);
        rdc(A_PRI, 32'h5);
        wr(A_CTL, 16'h0000, OK);
        for (d = 1; d < 3; d++) begin
            run0 <= 0;
            wr(A_CTL, 16'(d), OK);
            chk("pin init", 32'(pin), 32'(d == 2));
            run0 <= 1;
            repeat (10) @(posedge clk);
            chk("pin match", 32'(pin), 32'(d == 1));
        end
        wr(A_CTL, 16'h0003, OK);
        meas();
        chk("toggle", hi, 16);
        wr(A_CTL, 16'h0000, OK);
        meas();
        chk("off", hi, 0);
        wr(A_PRI, 16'h0002, OK);
        wr(A_SEC, 16'h0005, OK);
        wr(A_CTL, 16'h0005, OK);
        repeat (10) @(posedge clk);
        meas();
        chk("cont hi", hi, 12);
        chk("cont irq", nirq, 4);
        run0 <= 0;
        wr(A_CTL, 16'h0004, OK);
        run0 <= 1;
        meas();
        chk("one rise", ri, 1);
        chk("one hi", hi, 3);
        chk("one irq", nirq, 1);
        meas();
        chk("after hi", hi, 0);
        wr(A_CTL, 16'h0000, OK);
        wr(A_PRI, 16'h0003, OK);
        wr(A_SEC, 16'h0003, OK);
        flt_n <= 0;
        wr(A_CTL, 16'h0007, OK);
        meas();
        chk("fault hi", hi, 0);
        chk("fault irq", nirq, 4);
        rdc(A_CTL, 32'h17);
        flt_n <= 1;
        wr(A_CTL, 16'h0016, OK);
        rdc(A_CTL, 32'h6);
        wr(A_PER1, 16'h0007, OK);
        run0 <= 0;
        run1 <= 1;
        wr(A_CTL, 16'h000e, OK);
        repeat (20) @(posedge clk);
        meas();
        chk("tsel hi", hi, 12);
        rd(A_TMR, OK, rdv);
        chk("count", 32'(rdv <= 7), 32'h1);
        idle <= 1;
        wr(A_CTL, 16'h200e, OK);
        meas();
        chk("idle stop", ri, 0);
        wr(A_CTL, 16'h000e, OK);
        meas();
        chk("idle run", ri, 4);
        conclude();
    end

    initial begin
        repeat (30000) @(posedge clk);
        failures++;
        conclude();
    end
endmodule // testbench
